// ==== sim/cpd_decoder_asserts.sv ====
// Checker for the control and operand decoder, bound to its top ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module cpd_decoder_asserts import cpd_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Handshakes
	input wire logic fetchReady,
	input wire logic decValid,
	input wire logic decReady,
	// Decoded fields
	input wire logic [7:0] decOpcode,
	input wire logic decWord,
	input wire logic decToReg,
	input wire logic decRegHigh,
	input wire logic decRmHigh,
	input wire logic [15:0] decEffAddr,
	input wire logic decEscape,
	input wire logic [7:0] decShiftCount,
	input wire logic decCondValid,
	input wire logic decIllegal
);
	// All checks share the system clock and its reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// A held request is answered in its second cycle
	property p_wait_second;
		(avs_read || avs_write) && avs_waitrequest ##1 (avs_read || avs_write) |-> !avs_waitrequest;
	endproperty
	a_wait_second: assert property (p_wait_second) else $error("waitrequest not low in second cycle");
	property p_word;
		decValid |-> decWord == decOpcode[0];
	endproperty
	a_word: assert property (p_word) else $error("width flag differs from opcode bit");
	property p_to_reg;
		decValid |-> decToReg == decOpcode[1];
	endproperty
	a_to_reg: assert property (p_to_reg) else $error("direction flag differs from opcode bit");
	// Word operands never pick a byte half
	property p_word_regs;
		decValid && decWord |-> !decRegHigh && !decRmHigh;
	endproperty
	a_word_regs: assert property (p_word_regs) else $error("high half chosen on word op");
	property p_escape;
		decValid |-> decEscape == (decOpcode[7:3] == 5'h1B);
	endproperty
	a_escape: assert property (p_escape) else $error("escape flag wrong");
	property p_shift_one;
		decValid && decOpcode[7:2] == 6'h34 && !decOpcode[1] |-> decShiftCount == 8'h01;
	endproperty
	a_shift_one: assert property (p_shift_one) else $error("single shift count wrong");
	property p_illegal;
		decValid && decIllegal |-> decOpcode == 8'h8E;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal flag on wrong opcode");
	property p_cond;
		decValid |-> decCondValid == (decOpcode[7:4] == 4'h7);
	endproperty
	a_cond: assert property (p_cond) else $error("condition flag on wrong opcode");
	// A stalled issue must not move under the execution unit
	property p_hold;
		decValid && !decReady |=> decValid && $stable(decOpcode) && $stable(decEffAddr);
	endproperty
	a_hold: assert property (p_hold) else $error("decoded output moved while stalled");
	// Issue is always preceded by the calculation cycle
	property p_calc_gap;
		$rose(decValid) |-> !$past(fetchReady);
	endproperty
	a_calc_gap: assert property (p_calc_gap) else $error("issue without calculation cycle");
endmodule

bind cpd_decoder cpd_decoder_asserts chk_u (.clk_sys, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
	.fetchReady, .decValid, .decReady, .decOpcode, .decWord, .decToReg, .decRegHigh, .decRmHigh, .decEffAddr,
	.decEscape, .decShiftCount, .decCondValid, .decIllegal);

// ==== sim/tb.sv ====
// Self-checking bench for the control and operand decoder.
// Assumes the package, params header and decoder compile first.
`timescale 1ns/1ps
module tb import cpd_pkg::*; ;
	// Clock, reset and register bus
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	// Byte stream and decoded instruction
	logic [7:0] fetchByte = 8'h00;
	logic fetchValid = 1'b0;
	logic fetchReady, decValid;
	logic decReady = 1'b0;
	logic [7:0] decOpcode, decShiftCount;
	logic decWord, decToReg, decRegHigh, decRmIsReg, decRmHigh, decLock, decEscape;
	logic decRepActive, decRepStop, decCondValid, decCondTrue, decIllegal;
	logic [2:0] decRegIdx, decRmIdx;
	logic [15:0] decEffAddr, decImm;
	logic [1:0] decSeg;
	// Bookkeeping
	int failures = 0;
	int checksDone = 0;
	int cycles = 0;
	logic [31:0] rdat;
	// Flag opcodes and the flag word expected after each
	logic [7:0] fop [8] = '{8'hF9, 8'hF5, 8'hF5, 8'hF8, 8'hFD, 8'hFC, 8'hFB, 8'hFA};
	logic [31:0] fexp [8] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h400, 32'h0, 32'h200, 32'h0};

	cpd_decoder dut_u (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .fetchByte, .fetchValid, .fetchReady, .decValid, .decReady, .decOpcode, .decWord,
		.decToReg, .decRegIdx, .decRegHigh, .decRmIsReg, .decRmIdx, .decRmHigh, .decEffAddr, .decSeg, .decLock,
		.decEscape, .decImm, .decShiftCount, .decRepActive, .decRepStop, .decCondValid, .decCondTrue, .decIllegal);

	// 250 MHz clock
	always #2 clk_sys = ~clk_sys;

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d failures %0d", checksDone, failures);
		if (failures == 0 && checksDone > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] seen);
		checksDone++;
		if (seen !== expv) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, expv, seen);
		end
	endtask

	// One bus access; request held until waitrequest is sampled low
	task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, e, rdat);
	endtask

	// Feed bytes, then wait for the issue; outputs stay held until ack
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			fetchByte <= q[i];
			fetchValid <= 1'b1;
			do @(posedge clk_sys); while (fetchReady !== 1'b1);
		end
		fetchValid <= 1'b0;
		while (decValid !== 1'b1) @(posedge clk_sys);
	endtask

	// Stall one cycle already passed in send; now take the issue
	task automatic ack();
		decReady <= 1'b1;
		@(posedge clk_sys);
		decReady <= 1'b0;
	endtask

	task automatic eat(input logic [7:0] q[$], input logic [15:0] e, input logic [1:0] s);
		send(q);
		chk("addr", e, decEffAddr);
		chk("seg", s, decSeg);
		ack();
	endtask

	task automatic cnd(input logic [7:0] op, input logic e);
		send('{op});
		chk("cond", {1'b1, e}, {decCondValid, decCondTrue});
		ack();
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdc("ctrl", 6'h00, 32'h1);
		rdc("flags", 6'h04, 32'h0);
		rdc("unmapped", 6'h3C, 32'h0);
		bus(1'b1, 6'h08, 32'h1000);
		bus(1'b1, 6'h0C, 32'h2000);
		bus(1'b1, 6'h10, 32'h0030);
		bus(1'b1, 6'h14, 32'h0004);
		bus(1'b1, 6'h18, 32'h0105);
		rdc("base", 6'h08, 32'h1000);
		// Every flag opcode, each read back through the flag word
		foreach (fop[i]) begin
			send('{fop[i]});
			ack();
			rdc("flags", 6'h04, fexp[i]);
		end
		// Addressing forms and segment choice
		eat('{8'h8B, 8'h00}, 16'h1030, 2'h3);
		eat('{8'h8B, 8'h03}, 16'h2004, 2'h2);
		eat('{8'h8B, 8'h46, 8'hFE}, 16'h1FFE, 2'h2);
		eat('{8'h8B, 8'h87, 8'h34, 8'h12}, 16'h2234, 2'h3);
		eat('{8'h8B, 8'h06, 8'h78, 8'h56}, 16'h5678, 2'h3);
		// Last address register ignores writes and keeps the direct address
		bus(1'b1, 6'h1C, 32'hFFFF);
		rdc("lastaddr", 6'h1C, 32'h5678);
		eat('{8'h26, 8'h8B, 8'h05}, 16'h0004, 2'h0);
		eat('{8'h2E, 8'h8B, 8'h04}, 16'h0030, 2'h1);
		// Displacement before immediate data
		send('{8'h81, 8'h47, 8'h10, 8'h34, 8'h12});
		chk("addr", 16'h1010, decEffAddr);
		chk("imm", 16'h1234, decImm);
		ack();
		send('{8'h83, 8'hC0, 8'hFF});
		chk("imm", 16'hFFFF, decImm);
		ack();
		// Register forms, byte then word
		send('{8'h8A, 8'hE7});
		chk("regs", 9'h187, {decRmIsReg, decToReg, decWord, decRegIdx, decRegHigh, decRmIdx[1:0]});
		chk("rmhi", 1'b1, decRmHigh);
		ack();
		send('{8'h89, 8'hE7});
		chk("regs", 10'h2C7, {decRmIsReg, decToReg, decWord, decRegIdx, decRegHigh, decRmIdx});
		ack();
		// Shift counts
		send('{8'hD3, 8'hC0});
		chk("count", 8'h05, decShiftCount);
		ack();
		send('{8'hD1, 8'hC0});
		chk("count", 8'h01, decShiftCount);
		ack();
		// Lock prefix reaches only the next instruction
		send('{8'hF0, 8'h88, 8'hC0});
		chk("lock", 1'b1, decLock);
		ack();
		send('{8'h88, 8'hC0});
		chk("lock", 1'b0, decLock);
		ack();
		send('{8'hD8, 8'hC0});
		chk("escape", 1'b1, decEscape);
		ack();
		// Code segment load refused, data segment load accepted
		send('{8'h8E, 8'hC8});
		chk("illegal", 1'b1, decIllegal);
		ack();
		bus(1'b0, 6'h20, 32'h0);
		chk("sticky", 1'b1, rdat[1]);
		// Twenty-five instructions issued so far, sticky set, idle
		chk("status", 32'h1902, rdat);
		// Writing one to the sticky bit clears it; the count stays
		bus(1'b1, 6'h20, 32'h2);
		rdc("status", 6'h20, 32'h1900);
		send('{8'h8E, 8'hD8});
		chk("illegal", 1'b0, decIllegal);
		ack();
		// Repeat compare stops when zero flag differs from prefix bit
		send('{8'hF3, 8'hA6});
		chk("rep", 2'h3, {decRepActive, decRepStop});
		ack();
		// Unsigned versus signed conditions
		bus(1'b1, 6'h04, 32'h0001);
		cnd(8'h72, 1'b1);
		bus(1'b1, 6'h04, 32'h0080);
		cnd(8'h7C, 1'b1);
		cnd(8'h7F, 1'b0);
		cnd(8'h77, 1'b1);
		// Intake is refused while software holds it disabled
		bus(1'b1, 6'h00, 32'h0);
		@(posedge clk_sys);
		chk("ready", 1'b0, fetchReady);
		bus(1'b1, 6'h00, 32'h1);
		final_report();
	end
endmodule

// ==== src/cpd_decoder.sv ====
// Processor-control and operand-field decoder with an Avalon-MM register slave.
// Assumes instruction bytes arrive on the same clock from the fetch path and the
// execution unit takes each decoded instruction with a valid/ready handshake.
`timescale 1ns/1ps
`include "cpd_params.svh"
module cpd_decoder import cpd_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Instruction byte stream
	input wire logic [7:0] fetchByte,
	input wire logic fetchValid,
	output logic fetchReady,
	// Decoded instruction to execution unit
	output logic decValid,
	input wire logic decReady,
	output logic [7:0] decOpcode,
	output logic decWord,
	output logic decToReg,
	output logic [2:0] decRegIdx,
	output logic decRegHigh,
	output logic decRmIsReg,
	output logic [2:0] decRmIdx,
	output logic decRmHigh,
	output logic [15:0] decEffAddr,
	output logic [1:0] decSeg,
	output logic decLock,
	output logic decEscape,
	output logic [15:0] decImm,
	output logic [7:0] decShiftCount,
	output logic decRepActive,
	output logic decRepStop,
	output logic decCondValid,
	output logic decCondTrue,
	output logic decIllegal
);
	cpd_state_t state; // Sequencer state
	cpd_state_t next_state; // Its next value
	logic ctrlEnable; // Software enable of byte intake
	logic [15:0] flags; // Flag word
	logic [15:0] baseB, basePtr, srcIndex, dstIndex, countReg; // Address and count registers
	logic illegalSticky; // Refused instruction seen
	logic [7:0] issueCount; // Instructions issued, wraps
	logic busAck; // Second cycle of a bus access
	logic [7:0] opByte, modrmByte; // Captured bytes
	logic [15:0] dispVal, immVal; // Displacement and immediate
	logic lockPend, segOvr, repPend, repZ; // Prefix state
	logic [1:0] segOvrCode; // Override segment
	logic byteTaken; // Handshake on intake
	logic issueTaken; // Handshake on issue
	logic accessTaken; // Bus access completes this edge

	assign byteTaken = fetchValid & fetchReady;
	assign issueTaken = decValid & decReady;
	assign accessTaken = (avs_read | avs_write) & busAck;

	// Intake stalls while calculating or waiting on the execution unit
	assign fetchReady = ctrlEnable & (state != CPD_CALC) & (state != CPD_ISSUE);
	assign decValid = (state == CPD_ISSUE);

	// Opcodes that carry an addressing byte
	function automatic logic hasModrm(input logic [7:0] b);
		hasModrm = (b[7:6] == 2'b00 && b[2] == 1'b0) || (b[7:2] == 6'b100000)
			|| (b[7:2] == 6'b100001) || (b[7:2] == 6'b100010)
			|| (b[7:2] == 6'b100011 && b[0] == 1'b0) || (b[7:2] == 6'b110100)
			|| (b[7:3] == 5'b11011)
			|| (b[7:1] == 7'b1111011) || (b[7:1] == 7'b1111111);
	endfunction

	// Immediate group with sign/width bits
	function automatic logic hasImm(input logic [7:0] b);
		hasImm = (b[7:2] == 6'b100000);
	endfunction

	// Step after the addressing byte or the displacement
	function automatic cpd_state_t afterDisp(input logic [7:0] op);
		afterDisp = hasImm(op) ? CPD_IMMLO : CPD_CALC;
	endfunction

	// Prefix bytes stay in intake and only set pending state
	function automatic logic isPrefix(input logic [7:0] b);
		isPrefix = (b == `CPD_OP_LOCK) || (b[7:1] == 7'b1111001)
			|| (b[7:5] == `CPD_SEG_CODE && b[2:0] == 3'b110);
	endfunction

	// Sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			CPD_IDLE: begin
				if (byteTaken && !isPrefix(fetchByte)) begin
					next_state = hasModrm(fetchByte) ? CPD_MODRM : CPD_CALC;
				end
			end
			CPD_MODRM: begin
				if (byteTaken) begin
					if (fetchByte[7:6] == `CPD_MOD_REG) begin
						next_state = afterDisp(opByte);
					end else if (fetchByte[7:6] == `CPD_MOD_NODISP) begin
						// Direct form still fetches a word
						next_state = (fetchByte[2:0] == `CPD_RM_DIRECT) ? CPD_DISPLO : afterDisp(opByte);
					end else begin
						next_state = CPD_DISPLO;
					end
				end
			end
			CPD_DISPLO: begin
				if (byteTaken) begin
					// Short form has no high byte
					next_state = (modrmByte[7:6] == `CPD_MOD_DISP8) ? afterDisp(opByte) : CPD_DISPHI;
				end
			end
			CPD_DISPHI: begin
				if (byteTaken) begin
					next_state = afterDisp(opByte);
				end
			end
			CPD_IMMLO: begin
				if (byteTaken) begin
					next_state = (opByte[1:0] == 2'b01) ? CPD_IMMHI : CPD_CALC;
				end
			end
			CPD_IMMHI: begin
				if (byteTaken) begin
					next_state = CPD_CALC;
				end
			end
			CPD_CALC: next_state = CPD_ISSUE;
			CPD_ISSUE: begin
				if (issueTaken) begin
					next_state = CPD_IDLE;
				end
			end
			default: next_state = CPD_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= CPD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Byte capture; displacement precedes immediate in the stream
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			opByte <= 8'h00;
			modrmByte <= 8'h00;
			dispVal <= 16'h0000;
			immVal <= 16'h0000;
		end else if (byteTaken) begin
			case (state)
				CPD_IDLE: begin
					if (!isPrefix(fetchByte)) begin
						opByte <= fetchByte;
						modrmByte <= 8'h00;
						dispVal <= 16'h0000;
						immVal <= 16'h0000;
					end
				end
				CPD_MODRM: modrmByte <= fetchByte;
				CPD_DISPLO: dispVal <= {{8{fetchByte[7]}}, fetchByte};
				CPD_DISPHI: dispVal <= {fetchByte, dispVal[7:0]};
				CPD_IMMLO: begin
					// Sign-extend only for s:w 11
					immVal <= {((opByte[1:0] == 2'b11) ? {8{fetchByte[7]}} : 8'h00), fetchByte};
				end
				CPD_IMMHI: immVal <= {fetchByte, immVal[7:0]};
				default: immVal <= immVal;
			endcase
		end
	end

	// Prefix state lives until the following instruction is issued
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lockPend <= 1'b0;
			segOvr <= 1'b0;
			segOvrCode <= 2'h0;
			repPend <= 1'b0;
			repZ <= 1'b0;
		end else if (issueTaken) begin
			lockPend <= 1'b0;
			segOvr <= 1'b0;
			repPend <= 1'b0;
		end else if (byteTaken && state == CPD_IDLE) begin
			if (fetchByte == `CPD_OP_LOCK) begin
				lockPend <= 1'b1;
			end
			if (fetchByte[7:1] == 7'b1111001) begin
				repPend <= 1'b1;
				repZ <= fetchByte[0];
			end
			if (fetchByte[7:5] == `CPD_SEG_CODE && fetchByte[2:0] == 3'b110) begin
				segOvr <= 1'b1;
				segOvrCode <= fetchByte[4:3];
			end
		end
	end

	// Effective address from the r/m selected bases
	logic [15:0] addrBase; // Base sum before displacement
	always_comb begin
		case (modrmByte[2:0])
			3'h0: addrBase = baseB + srcIndex;
			3'h1: addrBase = baseB + dstIndex;
			3'h2: addrBase = basePtr + srcIndex;
			3'h3: addrBase = basePtr + dstIndex;
			3'h4: addrBase = srcIndex;
			3'h5: addrBase = dstIndex;
			3'h6: addrBase = basePtr;
			default: addrBase = baseB;
		endcase
	end

	logic isDirect; // Mode 00, r/m 110
	logic usesStack; // Base pointer forms default to stack segment
	logic [3:0] cc; // Condition field of a conditional jump
	logic condRaw; // Condition before inversion
	assign isDirect = (modrmByte[7:6] == `CPD_MOD_NODISP) && (modrmByte[2:0] == `CPD_RM_DIRECT);
	assign usesStack = !isDirect && (modrmByte[2:0] == 3'h2 || modrmByte[2:0] == 3'h3 || modrmByte[2:0] == 3'h6);
	assign cc = opByte[3:0];

	// Above/below use carry and zero only; greater/less use sign against overflow
	always_comb begin
		case (cc[3:1])
			3'h0: condRaw = flags[`CPD_OVERFLOW_FLAG];
			3'h1: condRaw = flags[`CPD_CARRY_FLAG];
			3'h2: condRaw = flags[`CPD_ZERO_FLAG];
			3'h3: condRaw = flags[`CPD_CARRY_FLAG] | flags[`CPD_ZERO_FLAG];
			3'h4: condRaw = flags[`CPD_SIGN_FLAG];
			3'h5: condRaw = flags[`CPD_PARITY_FLAG];
			3'h6: condRaw = flags[`CPD_SIGN_FLAG] ^ flags[`CPD_OVERFLOW_FLAG];
			default: condRaw = (flags[`CPD_SIGN_FLAG] ^ flags[`CPD_OVERFLOW_FLAG]) | flags[`CPD_ZERO_FLAG];
		endcase
	end

	// Decoded fields registered in the calculate step
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			decOpcode <= 8'h00;
			decWord <= 1'b0;
			decToReg <= 1'b0;
			decRegIdx <= 3'h0;
			decRegHigh <= 1'b0;
			decRmIsReg <= 1'b0;
			decRmIdx <= 3'h0;
			decRmHigh <= 1'b0;
			decEffAddr <= 16'h0000;
			decSeg <= 2'h0;
			decLock <= 1'b0;
			decEscape <= 1'b0;
			decImm <= 16'h0000;
			decShiftCount <= 8'h00;
			decRepActive <= 1'b0;
			decRepStop <= 1'b0;
			decCondValid <= 1'b0;
			decCondTrue <= 1'b0;
			decIllegal <= 1'b0;
		end else if (state == CPD_CALC) begin
			decOpcode <= opByte;
			decWord <= opByte[0];
			decToReg <= opByte[1];
			// Byte codes 1xx pick the high half of the first four registers
			decRegIdx <= opByte[0] ? modrmByte[5:3] : {1'b0, modrmByte[4:3]};
			decRegHigh <= !opByte[0] && modrmByte[5];
			decRmIsReg <= (modrmByte[7:6] == `CPD_MOD_REG);
			decRmIdx <= opByte[0] ? modrmByte[2:0] : {1'b0, modrmByte[1:0]};
			decRmHigh <= !opByte[0] && modrmByte[2];
			decEffAddr <= isDirect ? dispVal : addrBase + dispVal;
			decSeg <= segOvr ? segOvrCode : (usesStack ? CPD_SEG_STACK : CPD_SEG_DATA);
			decLock <= lockPend;
			decEscape <= (opByte[7:3] == 5'b11011);
			decImm <= immVal;
			// Count register low byte only when the count bit is set
			decShiftCount <= opByte[1] ? countReg[7:0] : 8'h01;
			decRepActive <= repPend;
			// Compare/scan stop once the zero flag differs from the prefix bit
			decRepStop <= repPend && (opByte[7:1] == 7'b1010011 || opByte[7:1] == 7'b1010111)
				&& (flags[`CPD_ZERO_FLAG] != repZ);
			decCondValid <= (opByte[7:4] == 4'h7);
			decCondTrue <= condRaw ^ cc[0];
			// Move into the code segment is flagged and never carried out
			decIllegal <= (opByte == `CPD_OP_MOVE_TO_SEG) && (modrmByte[5:3] == {1'b0, CPD_SEG_CODE_S});
		end
	end

	// Flag word: processor-control opcodes win over a software write in the same edge
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flags <= `CPD_FLAGS_RST;
		end else begin
			if (accessTaken && avs_write && avs_address == `CPD_ADDR_FLAGS) begin
				flags <= avs_writedata[15:0] & `CPD_FLAGS_MASK;
			end
			if (issueTaken && !decIllegal) begin
				case (decOpcode)
					`CPD_OP_CARRY_CLEAR: flags[`CPD_CARRY_FLAG] <= 1'b0;
					`CPD_OP_CARRY_INVERT: flags[`CPD_CARRY_FLAG] <= ~flags[`CPD_CARRY_FLAG];
					`CPD_OP_CARRY_SET: flags[`CPD_CARRY_FLAG] <= 1'b1;
					`CPD_OP_DIR_CLEAR: flags[`CPD_DIRECTION_FLAG] <= 1'b0;
					`CPD_OP_DIR_SET: flags[`CPD_DIRECTION_FLAG] <= 1'b1;
					`CPD_OP_INT_CLEAR: flags[`CPD_INT_ENABLE_FLAG] <= 1'b0;
					`CPD_OP_INT_SET: flags[`CPD_INT_ENABLE_FLAG] <= 1'b1;
					// Other opcodes touch nothing, so a same-edge software write still lands
					default: ;
				endcase
			end
		end
	end

	// Software registers for address bases, count and control
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrlEnable <= `CPD_CTRL_RST;
			baseB <= 16'h0000;
			basePtr <= 16'h0000;
			srcIndex <= 16'h0000;
			dstIndex <= 16'h0000;
			countReg <= 16'h0000;
		end else if (accessTaken && avs_write) begin
			case (avs_address)
				`CPD_ADDR_CTRL: ctrlEnable <= avs_writedata[0];
				`CPD_ADDR_BASE_B: baseB <= avs_writedata[15:0];
				`CPD_ADDR_BASE_PTR: basePtr <= avs_writedata[15:0];
				`CPD_ADDR_SRC_INDEX: srcIndex <= avs_writedata[15:0];
				`CPD_ADDR_DST_INDEX: dstIndex <= avs_writedata[15:0];
				`CPD_ADDR_COUNT: countReg <= avs_writedata[15:0];
				default: ctrlEnable <= ctrlEnable;
			endcase
		end
	end

	// Refused-instruction sticky bit and issue counter; a new event beats the clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			illegalSticky <= 1'b0;
			issueCount <= 8'h00;
		end else begin
			if (issueTaken && decIllegal) begin
				illegalSticky <= 1'b1;
			end else if (accessTaken && avs_write && avs_address == `CPD_ADDR_STATUS
				&& avs_writedata[`CPD_STAT_ILLEGAL]) begin
				illegalSticky <= 1'b0;
			end
			if (issueTaken) begin
				issueCount <= issueCount + 8'h01;
			end
		end
	end

	// Every access waits one cycle so read data can come from a flop
	assign avs_waitrequest = (avs_read | avs_write) & ~busAck;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			busAck <= 1'b0;
		end else begin
			busAck <= (avs_read | avs_write) & ~busAck;
		end
	end

	// Read mux, loaded on the first cycle of a read; unmapped reads zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !busAck) begin
			case (avs_address)
				`CPD_ADDR_CTRL: avs_readdata <= {31'h00000000, ctrlEnable};
				`CPD_ADDR_FLAGS: avs_readdata <= {16'h0000, flags & `CPD_FLAGS_MASK};
				`CPD_ADDR_BASE_B: avs_readdata <= {16'h0000, baseB};
				`CPD_ADDR_BASE_PTR: avs_readdata <= {16'h0000, basePtr};
				`CPD_ADDR_SRC_INDEX: avs_readdata <= {16'h0000, srcIndex};
				`CPD_ADDR_DST_INDEX: avs_readdata <= {16'h0000, dstIndex};
				`CPD_ADDR_COUNT: avs_readdata <= {16'h0000, countReg};
				`CPD_ADDR_LAST_EFF: avs_readdata <= {16'h0000, decEffAddr};
				`CPD_ADDR_STATUS: avs_readdata <= {16'h0000, issueCount, 6'h00, illegalSticky, state != CPD_IDLE};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end
endmodule

// ==== src/cpd_params.svh ====
// Constants for the control and operand decoder: bus offsets, field positions,
// opcodes and reset values. Assumes inclusion by the decoder module only.
//
// Notes on behaviour
// - Decode carry clear, invert, set opcodes.
// - Decode direction flag clear and set opcodes.
// - Decode interrupt enable clear and set opcodes.
// - Escape opcodes take addressing byte, external operand.
// - Lock prefix applies to following instruction.
// - Width bit set means word, clear byte.
// - Direction bit set makes register the destination.
// - Mode 11 makes r/m a register selector.
// - Mode 00 has zero displacement, except direct.
// - Mode 01 fetches one byte, sign-extended.
// - Mode 10 fetches two bytes, low first.
// - Address adds displacement to r/m selected bases.
// - Mode 00 r/m 110 is direct address.
// - Displacement follows second byte, before immediate data.
// - Loading code segment by move is refused.
// - s:w 01 word immediate, 11 sign-extended byte.
// - Count bit clear shifts once, else count low.
// - Repeat low bit compared with zero flag.
// - Segment override prefix selects next operand segment.
// - Register codes map words and byte halves.
// - Flag word bits at fixed positions.
// - Above/below unsigned, greater/less signed conditions.
`ifndef CPD_PARAMS_SVH
`define CPD_PARAMS_SVH
// Register byte offsets
`define CPD_ADDR_CTRL 6'h00
`define CPD_ADDR_FLAGS 6'h04
`define CPD_ADDR_BASE_B 6'h08
`define CPD_ADDR_BASE_PTR 6'h0C
`define CPD_ADDR_SRC_INDEX 6'h10
`define CPD_ADDR_DST_INDEX 6'h14
`define CPD_ADDR_COUNT 6'h18
`define CPD_ADDR_LAST_EFF 6'h1C
`define CPD_ADDR_STATUS 6'h20
// Reset values and flag word mask
`define CPD_CTRL_RST 1'h1
`define CPD_FLAGS_RST 16'h0000
`define CPD_FLAGS_MASK 16'h0FD5
// Flag word bit positions
`define CPD_CARRY_FLAG 0
`define CPD_PARITY_FLAG 2
`define CPD_AUX_CARRY_FLAG 4
`define CPD_ZERO_FLAG 6
`define CPD_SIGN_FLAG 7
`define CPD_TRAP_FLAG 8
`define CPD_INT_ENABLE_FLAG 9
`define CPD_DIRECTION_FLAG 10
`define CPD_OVERFLOW_FLAG 11
// Status bit positions
`define CPD_STAT_BUSY 0
`define CPD_STAT_ILLEGAL 1
// Single-byte opcodes
`define CPD_OP_CARRY_CLEAR 8'hF8
`define CPD_OP_CARRY_INVERT 8'hF5
`define CPD_OP_CARRY_SET 8'hF9
`define CPD_OP_DIR_CLEAR 8'hFC
`define CPD_OP_DIR_SET 8'hFD
`define CPD_OP_INT_CLEAR 8'hFA
`define CPD_OP_INT_SET 8'hFB
`define CPD_OP_LOCK 8'hF0
`define CPD_OP_MOVE_TO_SEG 8'h8E
// Field codes
`define CPD_SEG_CODE 3'h1
`define CPD_MOD_REG 2'h3
`define CPD_MOD_NODISP 2'h0
`define CPD_MOD_DISP8 2'h1
`define CPD_RM_DIRECT 3'h6
`endif

// ==== src/cpd_pkg.sv ====
// Types shared by the control and operand decoder.
// Assumes the params header is compiled alongside.
package cpd_pkg;
	// Decode sequencer, one-hot
	typedef enum logic [7:0] {
		CPD_IDLE = 8'h01,
		CPD_MODRM = 8'h02,
		CPD_DISPLO = 8'h04,
		CPD_DISPHI = 8'h08,
		CPD_IMMLO = 8'h10,
		CPD_IMMHI = 8'h20,
		CPD_CALC = 8'h40,
		CPD_ISSUE = 8'h80
	} cpd_state_t;
	// Segment codes as carried in the override prefix
	typedef enum logic [1:0] {
		CPD_SEG_EXTRA = 2'h0,
		CPD_SEG_CODE_S = 2'h1,
		CPD_SEG_STACK = 2'h2,
		CPD_SEG_DATA = 2'h3
	} cpd_seg_t;
endpackage
